/* common/awru_defs.svh */
// Constants for the accelerometer interrupt and wake-up router.
// Assumes inclusion by the router module only, not by the package.
`ifndef AWRU_DEFS_SVH
`define AWRU_DEFS_SVH

// Register addresses
`define AWRU_ADDR_PULSE_CFG   8'h0B
`define AWRU_ADDR_PIN1_CTRL   8'h0D
`define AWRU_ADDR_PIN2_CTRL   8'h0E
`define AWRU_ADDR_CTRL_THREE  8'h12
`define AWRU_ADDR_CTRL_FOUR   8'h13
`define AWRU_ADDR_CTRL_FIVE   8'h14
`define AWRU_ADDR_ALL_SRC     8'h1A
`define AWRU_ADDR_WAKE_SRC    8'h1B
`define AWRU_ADDR_OUT_FIRST   8'h28
`define AWRU_ADDR_OUT_LAST    8'h2D
`define AWRU_ADDR_WAKE_CFG    8'h56
`define AWRU_ADDR_INT_EN      8'h58
`define AWRU_ADDR_WAKE_THS    8'h5B
`define AWRU_ADDR_WAKE_DURATION    8'h5C
`define AWRU_ADDR_PIN1_EVT    8'h5E
`define AWRU_ADDR_PIN2_EVT    8'h5F
`define AWRU_ADDR_OFS_X       8'h73

// Writable bit masks, others read zero
`define AWRU_MASK_PIN_CTRL    8'h7D
`define AWRU_MASK_PIN_EVT     8'hA1
`define AWRU_MASK_PIN1_EVT    8'hA0

// Field positions
`define AWRU_BIT_POL_LOW      5
`define AWRU_BIT_OPEN_DRAIN   4
`define AWRU_BIT_MERGE        5
`define AWRU_BIT_ROUND_LO     5
`define AWRU_BIT_LATCH        0
`define AWRU_BIT_FILT_SEL     4
`define AWRU_BIT_INT_EN       7
`define AWRU_BIT_OFS_APPLY    6
`define AWRU_BIT_THS_WEIGHT   4
`define AWRU_BIT_DUR_LO       5
`define AWRU_BIT_DRDY_PULSED  0
`define AWRU_BIT_FS_LO        1
`define AWRU_BIT_OFS_WEIGHT   3
`define AWRU_BIT_ROUTE_ACT    7
`define AWRU_BIT_ROUTE_WAKE   5
`define AWRU_ROUND_OUT        2'b01

// Timing
`define AWRU_CLK_NS           8
`define AWRU_DRDY_PULSE_NS    18750
`define AWRU_DRDY_PULSE_CYC   (`AWRU_DRDY_PULSE_NS / `AWRU_CLK_NS)

`endif

/* common/awru_pkg.sv */
// Types for the accelerometer interrupt and wake-up router.
// Assumes the constants header sits beside it.
package awru_pkg;
  typedef logic [7:0] awru_byte_t;
  typedef logic signed [16:0] awru_wide_t;
  typedef enum {AWRU_SRC_SLOPE, AWRU_SRC_HPF, AWRU_SRC_LPF_OFS} awru_src_e;
endpackage

/* src/awru_axis_cmp.sv */
// Per-axis magnitude comparator for wake-up detection.
// Assumes a sign-extended sample and an already scaled threshold.
`timescale 1ns/1ns
module awru_axis_cmp
  import awru_pkg::*;
(
  // Sample and threshold
  input  wire awru_wide_t  sample,
  input  wire logic [16:0] thr,
  // Result
  output logic             over
);
  function automatic logic [16:0] mag(input awru_wide_t v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction

  // Strict compare, both signs via magnitude
  assign over = mag(sample) > thr;
endmodule

/* src/awru_pin_drv.sv */
// Interrupt pin driver with polarity and push-pull or open-drain output.
// Assumes the pad resolves out and oe; oe high while driving.
`timescale 1ns/1ns
module awru_pin_drv
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control
  input  wire logic level,
  input  wire logic pol_low,
  input  wire logic open_drain,
  // Pad
  output logic      pin_out,
  output logic      pin_oe
);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b1;
    end
    else
    begin
      pin_out <= level ^ pol_low;
      // Open drain drives only the active state
      pin_oe  <= open_drain ? level : 1'b1;
    end
  end
endmodule

/* src/awru_router.sv */
// Interrupt routing, wake-up detection and register port of the sensor.
// Assumes a decoded serial register port and one odr_strobe per sample.
//
// Summary of operation
// - Rounding 01b wraps burst reads 28h..2Dh
// - Polarity bit selects active high or low
// - Routing bits reset zero; set bit routes
// - Pin one control: FIFO, boot, data-ready enables
// - Pin one function: activity bit7, wake route
// - Pin two control layout, bit7 reads zero
// - Pin two function: activity, wake, timestamp
// - Routed events ORed onto their pin
// - Merge bit ORs all events onto pin one
// - Wake and activity need global enable
// - Latched event holds until source read
// - Latch only when routed to a pin
// - Filter select: slope or high-pass input
// - Select plus offset: low-pass minus offsets
// - Six-bit threshold, weight picks step
// - Exceed means magnitude strictly above threshold
// - Wake after duration consecutive over samples
// - Wake flag and axis flags in sources
// - Unlatched wake drops below threshold
// - Latched axis flags freeze until read
// - Latched data-ready clears on high-byte read
`timescale 1ns/1ns
`include "awru_defs.svh"
module awru_router
  import awru_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Sample stream, {z, y, x}
  input  wire logic        odr_strobe,
  input  wire logic [47:0] slope_data,
  input  wire logic [47:0] hpf_data,
  input  wire logic [47:0] lpf_data,
  // Event sources
  input  wire logic        ev_fifo_cnt_bdr,
  input  wire logic        ev_fifo_full,
  input  wire logic        ev_fifo_ovr,
  input  wire logic        ev_fifo_th,
  input  wire logic        ev_boot_done,
  input  wire logic        ev_temp_ready,
  input  wire logic        ev_tick_overflow,
  input  wire logic        ev_activity_change,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire awru_byte_t  reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        reg_rd_next,
  output awru_byte_t       reg_rdata,
  // Interrupt pads
  output logic             irq_pin_a_out,
  output logic             irq_pin_a_oe,
  output logic             irq_pin_b_out,
  output logic             irq_pin_b_oe
);
  awru_byte_t pin1_route_ctrl_q;
  awru_byte_t pin1_event_route_q;
  awru_byte_t pin2_route_ctrl_q;
  awru_byte_t pin2_event_route_q;
  awru_byte_t control_reg_three_q;
  awru_byte_t control_reg_four_q;
  awru_byte_t control_reg_five_q;
  awru_byte_t pulse_cfg_q;
  awru_byte_t wake_cfg_q;
  awru_byte_t int_en_q;
  awru_byte_t wake_threshold_reg_q;
  awru_byte_t wake_duration_reg_q;
  awru_byte_t user_offset_q [3];
  logic [47:0] accel_out_q;
  logic [7:0]  rd_ptr_q;
  logic [1:0]  dur_cnt_q;
  logic        wake_flag_q;
  logic [2:0]  wake_axes_q;
  logic        act_flag_q;
  logic        src_pend_q;
  logic        drdy_q;
  logic [11:0] pulse_cnt_q;

  logic [7:0]  rd_addr;
  logic        rd_any;
  awru_byte_t  rd_val;
  awru_src_e   src_sel;
  awru_wide_t  axis_in [3];
  logic [16:0] thr;
  logic [2:0]  over;
  logic        wake_now;
  logic        latch_wake;
  logic        latch_act;
  logic        src_read;
  logic        drdy_sig;
  logic [7:0]  ev_ctrl_a;
  logic [7:0]  ev_ctrl_b;
  logic [7:0]  ev_func;
  logic        lvl_a;
  logic        lvl_b;
  logic        pin_a_level;
  logic        pin_b_level;

  function automatic logic route_or(input awru_byte_t en, input logic [7:0] ev);
    route_or = |(en & ev);
  endfunction

  // Offset LSB is fixed in g, so its shift depends on the full scale code
  function automatic awru_wide_t ofs_scale(input awru_byte_t ofs, input logic w,
                                           input logic [1:0] fs);
    logic [3:0] sh;
    sh = 4'd4 + (w ? 4'd4 : 4'd0) - {2'b00, fs};
    ofs_scale = awru_wide_t'({{9{ofs[7]}}, ofs}) <<< sh;
  endfunction

  function automatic logic [7:0] next_addr(input logic [7:0] a, input logic [1:0] rnd);
    if (rnd == `AWRU_ROUND_OUT && a == `AWRU_ADDR_OUT_LAST)
      next_addr = `AWRU_ADDR_OUT_FIRST;
    else
      next_addr = a + 8'h01;
  endfunction

  // Register port
  assign rd_any  = reg_rd | reg_rd_next;
  assign rd_addr = reg_rd ? reg_addr
                 : next_addr(rd_ptr_q, control_reg_five_q[`AWRU_BIT_ROUND_LO +: 2]);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rd_ptr_q <= 8'h00;
    else if (rd_any)
      rd_ptr_q <= rd_addr;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin1_route_ctrl_q    <= 8'h00;
      pin1_event_route_q   <= 8'h00;
      pin2_route_ctrl_q    <= 8'h00;
      pin2_event_route_q   <= 8'h00;
      control_reg_three_q  <= 8'h00;
      control_reg_four_q   <= 8'h00;
      control_reg_five_q   <= 8'h00;
      pulse_cfg_q          <= 8'h00;
      wake_cfg_q           <= 8'h00;
      int_en_q             <= 8'h00;
      wake_threshold_reg_q <= 8'h00;
      wake_duration_reg_q  <= 8'h00;
      for (int i = 0; i < 3; i++)
        user_offset_q[i] <= 8'h00;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `AWRU_ADDR_PIN1_CTRL:  pin1_route_ctrl_q    <= reg_wdata & `AWRU_MASK_PIN_CTRL;
        `AWRU_ADDR_PIN1_EVT:   pin1_event_route_q   <= reg_wdata & `AWRU_MASK_PIN1_EVT;
        `AWRU_ADDR_PIN2_CTRL:  pin2_route_ctrl_q    <= reg_wdata & `AWRU_MASK_PIN_CTRL;
        `AWRU_ADDR_PIN2_EVT:   pin2_event_route_q   <= reg_wdata & `AWRU_MASK_PIN_EVT;
        `AWRU_ADDR_CTRL_THREE: control_reg_three_q  <= reg_wdata;
        `AWRU_ADDR_CTRL_FOUR:  control_reg_four_q   <= reg_wdata;
        `AWRU_ADDR_CTRL_FIVE:  control_reg_five_q   <= reg_wdata;
        `AWRU_ADDR_PULSE_CFG:  pulse_cfg_q          <= reg_wdata;
        `AWRU_ADDR_WAKE_CFG:   wake_cfg_q           <= reg_wdata;
        `AWRU_ADDR_INT_EN:     int_en_q             <= reg_wdata;
        `AWRU_ADDR_WAKE_THS:   wake_threshold_reg_q <= reg_wdata;
        `AWRU_ADDR_WAKE_DURATION:   wake_duration_reg_q  <= reg_wdata;
        `AWRU_ADDR_OFS_X:      user_offset_q[0]     <= reg_wdata;
        `AWRU_ADDR_OFS_X + 8'h01: user_offset_q[1]  <= reg_wdata;
        `AWRU_ADDR_OFS_X + 8'h02: user_offset_q[2]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_val = 8'h00;
    unique case (rd_addr)
      `AWRU_ADDR_PIN1_CTRL:  rd_val = pin1_route_ctrl_q;
      `AWRU_ADDR_PIN1_EVT:   rd_val = pin1_event_route_q;
      `AWRU_ADDR_PIN2_CTRL:  rd_val = pin2_route_ctrl_q;
      `AWRU_ADDR_PIN2_EVT:   rd_val = pin2_event_route_q;
      `AWRU_ADDR_CTRL_THREE: rd_val = control_reg_three_q;
      `AWRU_ADDR_CTRL_FOUR:  rd_val = control_reg_four_q;
      `AWRU_ADDR_CTRL_FIVE:  rd_val = control_reg_five_q;
      `AWRU_ADDR_PULSE_CFG:  rd_val = pulse_cfg_q;
      `AWRU_ADDR_WAKE_CFG:   rd_val = wake_cfg_q;
      `AWRU_ADDR_INT_EN:     rd_val = int_en_q;
      `AWRU_ADDR_WAKE_THS:   rd_val = wake_threshold_reg_q;
      `AWRU_ADDR_WAKE_DURATION:   rd_val = wake_duration_reg_q;
      `AWRU_ADDR_OFS_X:      rd_val = user_offset_q[0];
      `AWRU_ADDR_OFS_X + 8'h01: rd_val = user_offset_q[1];
      `AWRU_ADDR_OFS_X + 8'h02: rd_val = user_offset_q[2];
      `AWRU_ADDR_WAKE_SRC:   rd_val = {2'b00, act_flag_q, 1'b0, wake_flag_q, wake_axes_q};
      `AWRU_ADDR_ALL_SRC:    rd_val = {2'b00, act_flag_q, 3'b000, wake_flag_q, 1'b0};
      default:
        if (rd_addr >= `AWRU_ADDR_OUT_FIRST && rd_addr <= `AWRU_ADDR_OUT_LAST)
          rd_val = accel_out_q[8 * (rd_addr - `AWRU_ADDR_OUT_FIRST) +: 8];
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (rd_any)
      reg_rdata <= rd_val;
  end

  // Output data registers refresh once per sample
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      accel_out_q <= 48'h0000_0000_0000;
    else if (odr_strobe)
      accel_out_q <= lpf_data;
  end

  // Wake-up input selection and threshold
  always_comb
  begin
    if (!wake_cfg_q[`AWRU_BIT_FILT_SEL])
      src_sel = AWRU_SRC_SLOPE;
    else if (wake_threshold_reg_q[`AWRU_BIT_OFS_APPLY])
      src_sel = AWRU_SRC_LPF_OFS;
    else
      src_sel = AWRU_SRC_HPF;
    for (int i = 0; i < 3; i++)
    begin
      unique case (src_sel)
        AWRU_SRC_SLOPE: axis_in[i] = awru_wide_t'($signed(slope_data[16 * i +: 16]));
        AWRU_SRC_HPF:   axis_in[i] = awru_wide_t'($signed(hpf_data[16 * i +: 16]));
        AWRU_SRC_LPF_OFS:
          axis_in[i] = awru_wide_t'($signed(lpf_data[16 * i +: 16]))
                     - ofs_scale(user_offset_q[i], pulse_cfg_q[`AWRU_BIT_OFS_WEIGHT],
                                 pulse_cfg_q[`AWRU_BIT_FS_LO +: 2]);
      endcase
    end
  end

  // Full scale spans 2^15 counts, so the step is 2^9 or 2^7 counts
  assign thr = wake_duration_reg_q[`AWRU_BIT_THS_WEIGHT]
             ? {4'b0000, wake_threshold_reg_q[5:0], 7'b000_0000}
             : {2'b00, wake_threshold_reg_q[5:0], 9'b0_0000_0000};

  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    awru_axis_cmp u_cmp
    (
      .sample (axis_in[g]),
      .thr    (thr),
      .over   (over[g])
    );
  end

  assign wake_now = int_en_q[`AWRU_BIT_INT_EN] & (|over)
                  & (dur_cnt_q >= wake_duration_reg_q[`AWRU_BIT_DUR_LO +: 2]);

  assign latch_wake = wake_cfg_q[`AWRU_BIT_LATCH]
                    & (pin1_event_route_q[`AWRU_BIT_ROUTE_WAKE]
                       | pin2_event_route_q[`AWRU_BIT_ROUTE_WAKE]);
  assign latch_act  = wake_cfg_q[`AWRU_BIT_LATCH]
                    & (pin1_event_route_q[`AWRU_BIT_ROUTE_ACT]
                       | pin2_event_route_q[`AWRU_BIT_ROUTE_ACT]);
  assign src_read   = rd_any & (rd_addr == `AWRU_ADDR_WAKE_SRC
                                | rd_addr == `AWRU_ADDR_ALL_SRC);

  // Consecutive over-threshold count, saturating
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      dur_cnt_q <= 2'b00;
    else if (src_read && wake_cfg_q[`AWRU_BIT_LATCH])
      dur_cnt_q <= 2'b00;
    else if (odr_strobe)
    begin
      if (!(|over) || !int_en_q[`AWRU_BIT_INT_EN])
        dur_cnt_q <= 2'b00;
      else if (dur_cnt_q != 2'b11)
        dur_cnt_q <= dur_cnt_q + 2'b01;
    end
  end

  // A read arms release; a new event at the next strobe still wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      src_pend_q <= 1'b0;
    else if (src_read)
      src_pend_q <= 1'b1;
    else if (odr_strobe)
      src_pend_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wake_flag_q <= 1'b0;
      wake_axes_q <= 3'b000;
    end
    else if (odr_strobe)
    begin
      if (!(latch_wake && wake_flag_q && !src_pend_q))
      begin
        wake_flag_q <= wake_now;
        wake_axes_q <= wake_now ? {over[0], over[1], over[2]} : 3'b000;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      act_flag_q <= 1'b0;
    else if (odr_strobe && !(latch_act && act_flag_q && !src_pend_q))
      act_flag_q <= int_en_q[`AWRU_BIT_INT_EN] & ev_activity_change;
  end

  // Data-ready: high-byte read clears, a new sample in the same cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      drdy_q <= 1'b0;
    else if (odr_strobe)
      drdy_q <= 1'b1;
    else if (rd_any && (rd_addr == `AWRU_ADDR_OUT_FIRST + 8'h01
                        || rd_addr == `AWRU_ADDR_OUT_FIRST + 8'h03
                        || rd_addr == `AWRU_ADDR_OUT_LAST))
      drdy_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pulse_cnt_q <= 12'h000;
    else if (odr_strobe)
      pulse_cnt_q <= 12'(`AWRU_DRDY_PULSE_CYC);
    else if (pulse_cnt_q != 12'h000)
      pulse_cnt_q <= pulse_cnt_q - 12'h001;
  end

  assign drdy_sig = pulse_cfg_q[`AWRU_BIT_DRDY_PULSED] ? (pulse_cnt_q != 12'h000) : drdy_q;

  // Routing
  assign ev_ctrl_a = {1'b0, ev_fifo_cnt_bdr, ev_fifo_full, ev_fifo_ovr, ev_fifo_th,
                      ev_boot_done, 1'b0, drdy_sig};
  assign ev_ctrl_b = {1'b0, ev_fifo_cnt_bdr, ev_fifo_full, ev_fifo_ovr, ev_fifo_th,
                      ev_temp_ready, 1'b0, drdy_sig};
  assign ev_func   = {act_flag_q, 1'b0, wake_flag_q, 4'h0, ev_tick_overflow};

  assign lvl_a = route_or(pin1_route_ctrl_q, ev_ctrl_a) | route_or(pin1_event_route_q, ev_func);
  assign lvl_b = route_or(pin2_route_ctrl_q, ev_ctrl_b) | route_or(pin2_event_route_q, ev_func);

  assign pin_a_level = control_reg_four_q[`AWRU_BIT_MERGE] ? (lvl_a | lvl_b) : lvl_a;
  assign pin_b_level = control_reg_four_q[`AWRU_BIT_MERGE] ? 1'b0 : lvl_b;

  awru_pin_drv u_pin_a
  (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .level      (pin_a_level),
    .pol_low    (control_reg_three_q[`AWRU_BIT_POL_LOW]),
    .open_drain (control_reg_three_q[`AWRU_BIT_OPEN_DRAIN]),
    .pin_out    (irq_pin_a_out),
    .pin_oe     (irq_pin_a_oe)
  );

  awru_pin_drv u_pin_b
  (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .level      (pin_b_level),
    .pol_low    (control_reg_three_q[`AWRU_BIT_POL_LOW]),
    .open_drain (control_reg_three_q[`AWRU_BIT_OPEN_DRAIN]),
    .pin_out    (irq_pin_b_out),
    .pin_oe     (irq_pin_b_oe)
  );
endmodule

/* tb/awru_host_model.sv */
// Host side of the two interrupt lines: resolves each pad into the level the host sees.
// Assumes host pull-ups on both lines, so a released open-drain pad reads high.
`timescale 1ns/1ns
module awru_host_model
(
  // Pads of the device
  input  wire logic irq_pin_a_out,
  input  wire logic irq_pin_a_oe,
  input  wire logic irq_pin_b_out,
  input  wire logic irq_pin_b_oe,
  // Levels at the host inputs
  output logic      lvl_a,
  output logic      lvl_b
);
  assign lvl_a = irq_pin_a_oe ? irq_pin_a_out : 1'b1;
  assign lvl_b = irq_pin_b_oe ? irq_pin_b_out : 1'b1;
endmodule

/* tb/awru_router_sva.sv */
// Checker for the register port and interrupt pads of the router.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module awru_router_sva
  import awru_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Events
  input wire logic       ev_fifo_th,
  input wire logic       ev_temp_ready,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire awru_byte_t reg_wdata,
  input wire logic       reg_rd,
  input wire awru_byte_t reg_rdata,
  // Pads
  input wire logic       irq_pin_a_out,
  input wire logic       irq_pin_a_oe,
  input wire logic       irq_pin_b_out,
  input wire logic       irq_pin_b_oe
);
  // Shadows move at the same edge as the design registers, so no skew to allow for
  logic [7:0] c1_q, c2_q, c3_q, c4_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      c3_q <= 8'h00;
      c4_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h0D)
        c1_q <= reg_wdata;
      if (reg_addr == 8'h0E)
        c2_q <= reg_wdata;
      if (reg_addr == 8'h12)
        c3_q <= reg_wdata;
      if (reg_addr == 8'h13)
        c4_q <= reg_wdata;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_push_high;
    !c3_q[5] && !c3_q[4];
  endsequence

  a_reset_idle: assert property ($fell(reset) |-> !irq_pin_a_out && !irq_pin_b_out
    && irq_pin_a_oe && irq_pin_b_oe) else $error("pads not idle low after reset");
  a_ctrl_a_bits: assert property (s_read(8'h0D) |=> !reg_rdata[7] && !reg_rdata[1])
    else $error("pin one control reserved bits set");
  a_ctrl_b_bits: assert property (s_read(8'h0E) |=> !reg_rdata[7] && !reg_rdata[1])
    else $error("pin two control reserved bits set");
  a_evt_a_bits: assert property (s_read(8'h5E) |=> reg_rdata[6] == 1'b0 && reg_rdata[4:0] == 5'h00)
    else $error("pin one function reserved bits set");
  a_evt_b_bits: assert property (s_read(8'h5F) |=> reg_rdata[6] == 1'b0 && reg_rdata[4:1] == 4'h0)
    else $error("pin two function reserved bits set");
  a_routed_or: assert property (s_push_high ##0 (ev_fifo_th && c1_q[3]) |=> irq_pin_a_out)
    else $error("routed event missing on pin one");
  a_merge_onto_a: assert property (s_push_high ##0 (c4_q[5] && ev_temp_ready && c2_q[2])
    |=> irq_pin_a_out) else $error("merged event missing on pin one");
  a_merge_b_quiet: assert property (c4_q[5] && !c3_q[4] |=> irq_pin_b_out == $past(c3_q[5]))
    else $error("pin two active while merged");
  a_push_pull_oe: assert property (!c3_q[4] |=> irq_pin_a_oe && irq_pin_b_oe)
    else $error("push-pull pad not driven");
  a_drain_low_only: assert property (c3_q[4] && c3_q[5] |=> !(irq_pin_a_oe && irq_pin_a_out))
    else $error("open-drain pad driven high");
endmodule

/* tb/awru_router_tb.sv */
// Self-checking bench for the interrupt router and wake-up detector.
// Assumes the router, its checker and the host line model are compiled first.
`timescale 1ns/1ns
module awru_router_tb;
  import awru_pkg::*;
  typedef struct {logic [7:0] c56, c5b, c5c; logic [15:0] sx, hx, lx; logic w;} awru_wcase_s;
  logic        ref_clk = 0, reset = 1, odr_strobe = 0, reg_wr = 0, reg_rd = 0;
  logic        reg_rd_next = 0, rd_seen = 0, ea, eb, lvl_a, lvl_b;
  logic        irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe;
  logic [47:0] slope_data = 0, hpf_data = 0, lpf_data = 0;
  logic [7:0]  ev = 0, reg_addr = 0, c1, c2, exp_q[$];
  awru_byte_t  reg_wdata = 0, reg_rdata;
  logic [31:0] rng = 32'h0000_DD7D;
  int          mismatches = 0, num_checks = 0, cycles = 0;
  event        pin_ev;
  logic [7:0]  ra[4] = '{8'h0D, 8'h5E, 8'h0E, 8'h5F};
  logic [7:0]  rm[4] = '{8'h7D, 8'hA0, 8'h7D, 8'hA1};
  // Threshold 1 is 512 counts, offset 0Ah is 160 counts, weight one gives 128
  awru_wcase_s wt[9] = '{'{8'h00, 8'h01, 8'h00, 16'h0201, 16'h0000, 16'h0000, 1'b1},
    '{8'h00, 8'h01, 8'h00, 16'h0200, 16'h0000, 16'h0000, 1'b0},
    '{8'h00, 8'h01, 8'h00, 16'hFDFF, 16'h0000, 16'h0000, 1'b1},
    '{8'h00, 8'h01, 8'h00, 16'h0000, 16'h0258, 16'h0000, 1'b0},
    '{8'h10, 8'h01, 8'h00, 16'h0000, 16'h0258, 16'h0000, 1'b1},
    '{8'h10, 8'h41, 8'h00, 16'h0000, 16'h0000, 16'h02A0, 1'b0},
    '{8'h10, 8'h41, 8'h00, 16'h0000, 16'h0000, 16'h02A1, 1'b1},
    '{8'h00, 8'h01, 8'h10, 16'h0081, 16'h0000, 16'h0000, 1'b1},
    '{8'h00, 8'h01, 8'h10, 16'h0080, 16'h0000, 16'h0000, 1'b0}};

  awru_router uut (.ref_clk(ref_clk), .reset(reset), .odr_strobe(odr_strobe),
    .slope_data(slope_data), .hpf_data(hpf_data), .lpf_data(lpf_data),
    .ev_fifo_cnt_bdr(ev[0]), .ev_fifo_full(ev[1]), .ev_fifo_ovr(ev[2]), .ev_fifo_th(ev[3]),
    .ev_boot_done(ev[4]), .ev_temp_ready(ev[5]), .ev_tick_overflow(ev[6]),
    .ev_activity_change(ev[7]), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rd_next(reg_rd_next), .reg_rdata(reg_rdata),
    .irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe(irq_pin_a_oe),
    .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe(irq_pin_b_oe));
  awru_host_model u_host (.irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe(irq_pin_a_oe),
    .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe(irq_pin_b_oe), .lvl_a(lvl_a), .lvl_b(lvl_b));

  always #4 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] e);
    num_checks++;
    if (got !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // A read answers one edge later, so the flag of the taking edge marks the result
  always @(posedge ref_clk)
  begin
    cycles++;
    rd_seen <= reg_rd | reg_rd_next;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  always @(negedge ref_clk)
    if (rd_seen)
      cmp(reg_rdata, exp_q.pop_front());
  always @(pin_ev)
    cmp({6'h00, lvl_b, lvl_a}, exp_q.pop_front());

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk) reg_wr = 0;
    // Idle edge, so back-to-back calls never set a strobe twice in one step
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk) reg_rd = 0;
    @(negedge ref_clk);
  endtask
  task automatic burst(input logic [7:0] a, input int n, input logic wrap);
    logic [7:0] p;
    p = a;
    for (int k = 0; k < n; k++)
    begin
      exp_q.push_back((p >= 8'h28 && p <= 8'h2D) ? lpf_data[8*(p-8'h28) +: 8] : 8'h00);
      p = (wrap && p == 8'h2D) ? 8'h28 : p + 8'h01;
    end
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk) reg_rd = 0;
    reg_rd_next = 1;
    repeat (n - 1) @(negedge ref_clk);
    reg_rd_next = 0;
  endtask
  // Pads follow a strobe by two edges
  task automatic pins(input logic [1:0] e);
    repeat (2) @(negedge ref_clk);
    exp_q.push_back({6'h00, e});
    -> pin_ev;
    @(negedge ref_clk);
  endtask
  task automatic samp(input logic [47:0] s);
    slope_data = s;
    odr_strobe = 1;
    @(negedge ref_clk) odr_strobe = 0;
    @(negedge ref_clk);
  endtask

  initial
  begin
    repeat (16) @(negedge ref_clk);
    reset = 0;
    foreach (ra[i]) rd(ra[i], 8'h00);
    foreach (ra[i]) wr(ra[i], 8'hFF);
    foreach (ra[i]) rd(ra[i], rm[i]);
    foreach (ra[i]) wr(ra[i], 8'h00);
    wr(8'hEE, 8'h5A);
    rd(8'hEE, 8'h00);
    $display("register test done");
    repeat (24)
    begin
      rng = xs(rng);
      c1 = rng[7:0] & 8'h7C;
      c2 = rng[15:8] & 8'h7C;
      wr(8'h0D, c1);
      wr(8'h0E, c2);
      wr(8'h5F, {7'h00, rng[16]});
      wr(8'h12, {2'b00, rng[17], 5'h00});
      wr(8'h13, {2'b00, rng[18], 5'h00});
      ev = {1'b0, rng[30:24]};
      ea = |(c1[6:2] & {ev[0], ev[1], ev[2], ev[3], ev[4]});
      eb = |(c2[6:2] & {ev[0], ev[1], ev[2], ev[3], ev[5]}) | (rng[16] & ev[6]);
      if (rng[18])
      begin
        ea = ea | eb;
        eb = 0;
      end
      pins({eb, ea} ^ {2{rng[17]}});
    end
    wr(8'h13, 8'h00);
    wr(8'h0E, 8'h00);
    wr(8'h5F, 8'h00);
    wr(8'h0D, 8'h08);
    wr(8'h12, 8'h30);
    ev = 8'h00;
    pins(2'b11);
    ev[3] = 1;
    pins(2'b10);
    ev = 8'h00;
    wr(8'h12, 8'h00);
    wr(8'h0D, 8'h00);
    $display("routing test done");
    wr(8'h73, 8'h0A);
    wr(8'h58, 8'h80);
    wr(8'h5E, 8'h20);
    foreach (wt[i])
    begin
      wr(8'h56, wt[i].c56);
      wr(8'h5B, wt[i].c5b);
      wr(8'h5C, wt[i].c5c);
      hpf_data = {32'h0000_0000, wt[i].hx};
      lpf_data = {32'h0000_0000, wt[i].lx};
      samp({32'h0000_0000, wt[i].sx});
      pins({1'b0, wt[i].w});
      rd(8'h1B, wt[i].w ? 8'h0C : 8'h00);
      rd(8'h1A, wt[i].w ? 8'h02 : 8'h00);
    end
    wr(8'h5C, 8'h40);
    wr(8'h56, 8'h00);
    repeat (2)
    begin
      samp(48'h0000_0000_0201);
      pins(2'b00);
    end
    samp(48'h0000_0000_0201);
    pins(2'b01);
    wr(8'h58, 8'h00);
    samp(48'h0000_0000_0201);
    pins(2'b00);
    wr(8'h58, 8'h80);
    wr(8'h5C, 8'h00);
    wr(8'h56, 8'h01);
    samp(48'h0000_0000_0201);
    pins(2'b01);
    samp(48'h0000_0201_0000);
    pins(2'b01);
    rd(8'h1B, 8'h0C);
    samp(48'h0000_0000_0000);
    pins(2'b00);
    wr(8'h5E, 8'h00);
    samp(48'h0000_0000_0201);
    samp(48'h0000_0000_0000);
    rd(8'h1B, 8'h00);
    $display("wake test done");
    wr(8'h56, 8'h00);
    wr(8'h5E, 8'h80);
    wr(8'h5F, 8'h80);
    ev[7] = 1;
    samp(48'h0000_0000_0000);
    pins(2'b11);
    ev[7] = 0;
    wr(8'h5E, 8'h00);
    wr(8'h5F, 8'h00);
    wr(8'h0D, 8'h01);
    wr(8'h14, 8'h20);
    rng = xs(rng);
    lpf_data[31:0] = rng;
    rng = xs(rng);
    lpf_data[47:32] = rng[15:0];
    samp(48'h0000_0000_0000);
    pins(2'b01);
    burst(8'h28, 7, 1'b1);
    pins(2'b00);
    wr(8'h14, 8'h00);
    burst(8'h2D, 2, 1'b0);
    wr(8'h0B, 8'h01);
    samp(48'h0000_0000_0000);
    pins(2'b01);
    repeat (2343) @(negedge ref_clk);
    pins(2'b00);
    $display("output test done");
    print_verdict();
  end
endmodule

bind awru_router awru_router_sva u_sva (.ref_clk(ref_clk), .reset(reset),
  .ev_fifo_th(ev_fifo_th), .ev_temp_ready(ev_temp_ready), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe(irq_pin_a_oe),
  .irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe(irq_pin_b_oe));
